// File: rtl/mcrm_pkg.sv
// constants, formats and carrier types of the meter configuration register map
package mcrm_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 32;
    localparam int PHASE_N = 3;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam logic [15:0] OFS_REACT_A = 16'hE516;
    localparam logic [15:0] OFS_REACT_B = 16'hE517;
    localparam logic [15:0] OFS_REACT_C = 16'hE518;
    localparam logic [15:0] OFS_APPAR_A = 16'hE519;
    localparam logic [15:0] OFS_APPAR_B = 16'hE51A;
    localparam logic [15:0] OFS_APPAR_C = 16'hE51B;
    localparam logic [15:0] OFS_CHECKSUM = 16'hE51F;
    localparam logic [15:0] OFS_NOM_VOLT = 16'hE520;
    localparam logic [15:0] OFS_PEAK_STAT = 16'hE600;
    localparam logic [15:0] OFS_DELAY_0 = 16'hE601;
    localparam logic [15:0] OFS_DELAY_1 = 16'hE602;
    localparam logic [15:0] OFS_DELAY_2 = 16'hE603;
    localparam logic [15:0] OFS_PERIOD = 16'hE607;
    localparam logic [15:0] OFS_NOLOAD = 16'hE608;
    localparam logic [15:0] OFS_LINE_CYC = 16'hE60C;
    localparam logic [15:0] OFS_ZX_TOUT = 16'hE60D;
    localparam logic [15:0] OFS_COMP_MODE = 16'hE60E;
    localparam logic [15:0] OFS_GAINS = 16'hE60F;
    localparam logic [15:0] OFS_PULSE_CFG = 16'hE610;
    localparam logic [15:0] OFS_PULSE1_DEN = 16'hE611;
    localparam logic [15:0] OFS_PULSE2_DEN = 16'hE612;
    localparam logic [15:0] OFS_PULSE3_DEN = 16'hE613;
    localparam logic [15:0] OFS_TRIM_A = 16'hE614;
    localparam logic [15:0] OFS_TRIM_B = 16'hE615;
    localparam logic [15:0] OFS_TRIM_C = 16'hE616;
    localparam logic [15:0] OFS_SIGN_FLAGS = 16'hE617;
    localparam logic [15:0] OFS_DEV_CFG = 16'hE618;
    localparam logic [15:0] OFS_MEAS_MODE = 16'hE700;
    localparam logic [15:0] OFS_ACC_MODE = 16'hE701;
    localparam logic [15:0] OFS_LINE_ACCUM = 16'hE702;
    localparam logic [15:0] OFS_PEAK_CYC = 16'hE703;
    localparam logic [15:0] OFS_SAG_CYC = 16'hE704;
    localparam logic [15:0] OFS_PULSE_LATCH = 16'hE705;
    localparam logic [15:0] OFS_CAPTURE_CFG = 16'hE706;
    localparam logic [15:0] OFS_DIE_REV = 16'hE707;
    localparam logic [15:0] OFS_SS_HELPER = 16'hEBFF;
    localparam logic [15:0] OFS_LOW_POWER = 16'hEC01;

    ////////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [31:0] RST_CHECKSUM = 32'h93D774E6;
    localparam logic [23:0] RST_NOM_VOLT = 24'h000000;
    localparam logic [15:0] RST_LINE_CYC = 16'hFFFF;
    localparam logic [15:0] RST_ZX_TOUT = 16'hFFFF;
    localparam logic [15:0] RST_COMP_MODE = 16'h01FF;
    localparam logic [15:0] RST_GAINS = 16'h0000;
    localparam logic [15:0] RST_PULSE_CFG = 16'h0E88;
    localparam logic [15:0] RST_PULSE_DEN = 16'h0000;
    localparam logic [9:0] RST_TRIM = 10'h000;
    localparam logic [15:0] RST_DEV_CFG = 16'h0000;
    localparam logic [7:0] RST_MEAS_MODE = 8'h16;
    localparam logic [7:0] RST_ACC_MODE = 8'h00;
    localparam logic [7:0] RST_LINE_ACCUM = 8'h78;
    localparam logic [7:0] RST_PEAK_CYC = 8'h00;
    localparam logic [7:0] RST_SAG_CYC = 8'h00;
    localparam logic [7:0] RST_PULSE_LATCH = 8'h01;
    localparam logic [7:0] RST_CAPTURE_CFG = 8'h00;
    localparam logic [7:0] RST_LOW_POWER = 8'h00;

    // transfer lengths in bytes
    localparam logic [2:0] LEN_8 = 3'h1;
    localparam logic [2:0] LEN_16 = 3'h2;
    localparam logic [2:0] LEN_32 = 3'h4;

    ////////////////////////////////////////////////////////////////////////////////
    // transfer formats
    typedef enum logic [2:0] {
        FMT_NONE,
        FMT_SE32,
        FMT_ZP32_24,
        FMT_ZP32_20,
        FMT_PLAIN32,
        FMT_PLAIN16,
        FMT_ZP16,
        FMT_PLAIN8
    } mcrm_fmt_t;

    ////////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic [PHASE_N-1:0][23:0] reactive;
        logic [PHASE_N-1:0][23:0] apparent;
        logic [PHASE_N-1:0][15:0] delay;
        logic [15:0] peakStatus;
        logic [15:0] period;
        logic [15:0] noLoad;
        logic [15:0] signFlags;
        logic checksumLoad;
        logic [31:0] checksumValue;
    } mcrm_meas_t;

    typedef struct packed {
        logic [23:0] nominalVoltage;
        logic [15:0] lineCycles;
        logic [15:0] zxTimeout;
        logic [15:0] computation_mode;
        logic [15:0] gains;
        logic [15:0] pulseCfg;
        logic [PHASE_N-1:0][15:0] pulseDen;
        logic [PHASE_N-1:0][9:0] phaseTrim;
        logic [15:0] devCfg;
        logic [7:0] measMode;
        logic [7:0] accumulation_mode;
        logic [7:0] lineAccum;
        logic [7:0] peakCycles;
        logic [7:0] sagCycles;
        logic [7:0] pulsesPerLatch;
        logic [7:0] capturePort;
        logic [7:0] lowPower;
    } mcrm_cfg_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [31:0] wrData;
        logic wrEn;
        logic rdEn;
    } mcrm_req_t;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [2:0] byteLen;
        logic [31:0] data;
    } mcrm_rsp_t;

endpackage

// File: rtl/mcrm_word_format.sv
// shapes a raw register value into its transfer word
`timescale 1ns/1ps
module mcrm_word_format
    import mcrm_pkg::*;
(
    input wire mcrm_fmt_t fmt,
    input wire logic [31:0] raw,
    output logic [31:0] word,
    output logic [2:0] byteLen
);
    always_comb begin
        word = 32'h00000000;
        byteLen = LEN_32;
        case (fmt)
            FMT_SE32: begin
                word = {{8{raw[23]}}, raw[23:0]};
            end
            FMT_ZP32_24: begin
                word = {8'h00, raw[23:0]};
            end
            FMT_ZP32_20: begin
                word = {12'h000, raw[19:0]};
            end
            FMT_PLAIN32: begin
                word = raw;
            end
            FMT_PLAIN16: begin
                word = {16'h0000, raw[15:0]};
                byteLen = LEN_16;
            end
            FMT_ZP16: begin
                word = {16'h0000, 6'h00, raw[9:0]};
                byteLen = LEN_16;
            end
            FMT_PLAIN8: begin
                word = {24'h000000, raw[7:0]};
                byteLen = LEN_8;
            end
            default: begin
                word = 32'h00000000;
                byteLen = LEN_8;
            end
        endcase
    end
endmodule

// File: rtl/mcrm_regs.sv
// register bank of the meter configuration map with readback formatting
`timescale 1ns/1ps
module mcrm_regs
    import mcrm_pkg::*;
#(
    parameter int PHASES = PHASE_N,
    parameter logic [7:0] DIE_REVISION = 8'h5A // arbitrary value
)
(
    input wire logic clock,
    input wire logic rst,
    input wire mcrm_req_t req,
    output mcrm_rsp_t rsp,
    input wire mcrm_meas_t meas,
    input wire logic pulseIn,
    input wire logic reducedPowerMode,
    output mcrm_cfg_t cfg,
    output logic [7:0] lowPowerActive,
    output logic energyLatch
);
    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    generate
        if (PHASES != PHASE_N) begin : g_bad_phases
            $error("mcrm_regs serves exactly three phases");
        end
        if (PHASE_N > 4) begin : g_bad_index
            $error("phase index is two bits wide");
        end
        if (ADDR_W != 16) begin : g_bad_addr
            $error("addresses are 16 bits wide");
        end
        if (DATA_W != 32) begin : g_bad_data
            $error("transfer words are 32 bits wide");
        end
        // phase windows are decoded by compare, so an overlap would shadow a register
        if (OFS_REACT_A + 16'(PHASE_N) > OFS_APPAR_A) begin : g_bad_power_map
            $error("reactive and apparent windows overlap");
        end
        if (OFS_PULSE1_DEN + 16'(PHASE_N) > OFS_TRIM_A) begin : g_bad_den_map
            $error("denominator and trim windows overlap");
        end
        if (OFS_TRIM_A + 16'(PHASE_N) > OFS_SIGN_FLAGS) begin : g_bad_trim_map
            $error("trim window runs into the sign flags");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        mcrm_cfg_t cfg;
        logic [31:0] checksum;
        logic [7:0] dieRev;
        logic [7:0] latchCount;
        logic energyLatch;
        mcrm_rsp_t rsp;
    } mcrm_state_t;

    localparam mcrm_cfg_t CFG_RESET = '{
        nominalVoltage: RST_NOM_VOLT,
        lineCycles: RST_LINE_CYC,
        zxTimeout: RST_ZX_TOUT,
        computation_mode: RST_COMP_MODE,
        gains: RST_GAINS,
        pulseCfg: RST_PULSE_CFG,
        pulseDen: {PHASE_N{RST_PULSE_DEN}},
        phaseTrim: {PHASE_N{RST_TRIM}},
        devCfg: RST_DEV_CFG,
        measMode: RST_MEAS_MODE,
        accumulation_mode: RST_ACC_MODE,
        lineAccum: RST_LINE_ACCUM,
        peakCycles: RST_PEAK_CYC,
        sagCycles: RST_SAG_CYC,
        pulsesPerLatch: RST_PULSE_LATCH,
        capturePort: RST_CAPTURE_CFG,
        lowPower: RST_LOW_POWER
    };

    localparam mcrm_state_t STATE_RESET = '{
        cfg: CFG_RESET,
        checksum: RST_CHECKSUM,
        dieRev: DIE_REVISION,
        latchCount: 8'h00,
        energyLatch: 1'b0,
        rsp: '{valid: 1'b0, hit: 1'b0, byteLen: LEN_8, data: 32'h00000000}
    };

    mcrm_state_t state_reg;
    mcrm_state_t state_next;

    mcrm_fmt_t rdFmt;
    logic [31:0] rdRaw;
    logic [31:0] rdWord;
    logic [2:0] rdLen;

    ////////////////////////////////////////////////////////////////////////////////
    // decoding shared by read and write paths
    function automatic logic is_phase_reg(input logic [15:0] a, input logic [15:0] base);
        return (a >= base) && (a < base + 16'(PHASE_N));
    endfunction

    function automatic logic [1:0] phase_of(input logic [15:0] a, input logic [15:0] base);
        logic [15:0] d;
        d = a - base;
        return d[1:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // read select: live measurement values, stored configuration otherwise
    always_comb begin
        rdFmt = FMT_NONE;
        rdRaw = 32'h00000000;
        if (is_phase_reg(req.addr, OFS_REACT_A)) begin
            rdFmt = FMT_SE32;
            rdRaw = {8'h00, meas.reactive[phase_of(req.addr, OFS_REACT_A)]};
        end else if (is_phase_reg(req.addr, OFS_APPAR_A)) begin
            rdFmt = FMT_SE32;
            rdRaw = {8'h00, meas.apparent[phase_of(req.addr, OFS_APPAR_A)]};
        end else if (is_phase_reg(req.addr, OFS_DELAY_0)) begin
            rdFmt = FMT_PLAIN16;
            rdRaw = {16'h0000, meas.delay[phase_of(req.addr, OFS_DELAY_0)]};
        end else if (is_phase_reg(req.addr, OFS_PULSE1_DEN)) begin
            rdFmt = FMT_PLAIN16;
            rdRaw = {16'h0000, state_reg.cfg.pulseDen[phase_of(req.addr, OFS_PULSE1_DEN)]};
        end else if (is_phase_reg(req.addr, OFS_TRIM_A)) begin
            rdFmt = FMT_ZP16;
            rdRaw = {22'h000000, state_reg.cfg.phaseTrim[phase_of(req.addr, OFS_TRIM_A)]};
        end else begin
            case (req.addr)
                OFS_CHECKSUM: begin
                    rdFmt = FMT_PLAIN32;
                    rdRaw = state_reg.checksum;
                end
                OFS_NOM_VOLT: begin
                    rdFmt = FMT_ZP32_24;
                    rdRaw = {8'h00, state_reg.cfg.nominalVoltage};
                end
                OFS_PEAK_STAT: begin
                    rdFmt = FMT_PLAIN16;
                    rdRaw = {16'h0000, meas.peakStatus};
                end
                OFS_PERIOD: begin
                    rdFmt = FMT_PLAIN16;
                    rdRaw = {16'h0000, meas.period};
                end
                OFS_NOLOAD: begin
                    rdFmt = FMT_PLAIN16;
                    rdRaw = {16'h0000, meas.noLoad};
                end
                OFS_LINE_CYC: begin
                    rdFmt = FMT_PLAIN16;
                    rdRaw = {16'h0000, state_reg.cfg.lineCycles};
                end
                OFS_ZX_TOUT: begin
                    rdFmt = FMT_PLAIN16;
                    rdRaw = {16'h0000, state_reg.cfg.zxTimeout};
                end
                OFS_COMP_MODE: begin
                    rdFmt = FMT_PLAIN16;
                    rdRaw = {16'h0000, state_reg.cfg.computation_mode};
                end
                OFS_GAINS: begin
                    rdFmt = FMT_PLAIN16;
                    rdRaw = {16'h0000, state_reg.cfg.gains};
                end
                OFS_PULSE_CFG: begin
                    rdFmt = FMT_PLAIN16;
                    rdRaw = {16'h0000, state_reg.cfg.pulseCfg};
                end
                OFS_SIGN_FLAGS: begin
                    rdFmt = FMT_PLAIN16;
                    rdRaw = {16'h0000, meas.signFlags};
                end
                OFS_DEV_CFG: begin
                    rdFmt = FMT_PLAIN16;
                    rdRaw = {16'h0000, state_reg.cfg.devCfg};
                end
                OFS_MEAS_MODE: begin
                    rdFmt = FMT_PLAIN8;
                    rdRaw = {24'h000000, state_reg.cfg.measMode};
                end
                OFS_ACC_MODE: begin
                    rdFmt = FMT_PLAIN8;
                    rdRaw = {24'h000000, state_reg.cfg.accumulation_mode};
                end
                OFS_LINE_ACCUM: begin
                    rdFmt = FMT_PLAIN8;
                    rdRaw = {24'h000000, state_reg.cfg.lineAccum};
                end
                OFS_PEAK_CYC: begin
                    rdFmt = FMT_PLAIN8;
                    rdRaw = {24'h000000, state_reg.cfg.peakCycles};
                end
                OFS_SAG_CYC: begin
                    rdFmt = FMT_PLAIN8;
                    rdRaw = {24'h000000, state_reg.cfg.sagCycles};
                end
                OFS_PULSE_LATCH: begin
                    rdFmt = FMT_PLAIN8;
                    rdRaw = {24'h000000, state_reg.cfg.pulsesPerLatch};
                end
                OFS_CAPTURE_CFG: begin
                    rdFmt = FMT_PLAIN8;
                    rdRaw = {24'h000000, state_reg.cfg.capturePort};
                end
                OFS_DIE_REV: begin
                    rdFmt = FMT_PLAIN8;
                    rdRaw = {24'h000000, state_reg.dieRev};
                end
                OFS_LOW_POWER: begin
                    rdFmt = FMT_PLAIN8;
                    rdRaw = {24'h000000, state_reg.cfg.lowPower};
                end
                default: begin
                    // reserved and unmapped locations, slave select helper among them
                    rdFmt = FMT_NONE;
                    rdRaw = 32'h00000000;
                end
            endcase
        end
    end

    mcrm_word_format u_format (
        .fmt(rdFmt),
        .raw(rdRaw),
        .word(rdWord),
        .byteLen(rdLen)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        state_next = state_reg;
        state_next.energyLatch = 1'b0;
        state_next.rsp.valid = 1'b0;

        // checksum is recomputed elsewhere; host writes never reach it
        if (meas.checksumLoad) begin
            state_next.checksum = meas.checksumValue;
        end

        if (req.wrEn) begin
            if (is_phase_reg(req.addr, OFS_PULSE1_DEN)) begin
                state_next.cfg.pulseDen[phase_of(req.addr, OFS_PULSE1_DEN)] =
                    req.wrData[15:0];
            end else if (is_phase_reg(req.addr, OFS_TRIM_A)) begin
                state_next.cfg.phaseTrim[phase_of(req.addr, OFS_TRIM_A)] =
                    req.wrData[9:0];
            end else begin
                case (req.addr)
                    OFS_NOM_VOLT: begin
                        state_next.cfg.nominalVoltage = req.wrData[23:0];
                    end
                    OFS_LINE_CYC: begin
                        state_next.cfg.lineCycles = req.wrData[15:0];
                    end
                    OFS_ZX_TOUT: begin
                        state_next.cfg.zxTimeout = req.wrData[15:0];
                    end
                    OFS_COMP_MODE: begin
                        state_next.cfg.computation_mode = req.wrData[15:0];
                    end
                    OFS_GAINS: begin
                        state_next.cfg.gains = req.wrData[15:0];
                    end
                    OFS_PULSE_CFG: begin
                        state_next.cfg.pulseCfg = req.wrData[15:0];
                    end
                    OFS_DEV_CFG: begin
                        state_next.cfg.devCfg = req.wrData[15:0];
                    end
                    OFS_MEAS_MODE: begin
                        state_next.cfg.measMode = req.wrData[7:0];
                    end
                    OFS_ACC_MODE: begin
                        state_next.cfg.accumulation_mode = req.wrData[7:0];
                    end
                    OFS_LINE_ACCUM: begin
                        state_next.cfg.lineAccum = req.wrData[7:0];
                    end
                    OFS_PEAK_CYC: begin
                        state_next.cfg.peakCycles = req.wrData[7:0];
                    end
                    OFS_SAG_CYC: begin
                        state_next.cfg.sagCycles = req.wrData[7:0];
                    end
                    OFS_PULSE_LATCH: begin
                        state_next.cfg.pulsesPerLatch = req.wrData[7:0];
                    end
                    OFS_CAPTURE_CFG: begin
                        state_next.cfg.capturePort = req.wrData[7:0];
                    end
                    OFS_DIE_REV: begin
                        state_next.dieRev = req.wrData[7:0];
                    end
                    OFS_LOW_POWER: begin
                        state_next.cfg.lowPower = req.wrData[7:0];
                    end
                    default: begin
                        // read-only, reserved and unmapped writes are dropped
                        state_next.cfg = state_reg.cfg;
                    end
                endcase
            end
        end

        // a pulse count of zero behaves as one, so the latch can never stall
        // a lowered limit below the running count latches on the next pulse
        if (pulseIn) begin
            if ((state_reg.latchCount + 8'h01) >= state_reg.cfg.pulsesPerLatch) begin
                state_next.latchCount = 8'h00;
                state_next.energyLatch = 1'b1;
            end else begin
                state_next.latchCount = state_reg.latchCount + 8'h01;
            end
        end

        if (req.rdEn) begin
            state_next.rsp.valid = 1'b1;
            state_next.rsp.hit = (rdFmt != FMT_NONE);
            state_next.rsp.byteLen = rdLen;
            state_next.rsp.data = rdWord;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs
    assign rsp = state_reg.rsp;
    assign cfg = state_reg.cfg;
    assign energyLatch = state_reg.energyLatch;
    // settings only take effect while the reduced power mode is active
    assign lowPowerActive = reducedPowerMode ? state_reg.cfg.lowPower : 8'h00;

endmodule

// File: tb/mcrm_dsp_model.sv
// measurement source standing in for the metering datapath
`timescale 1ns/1ps
module mcrm_dsp_model
    import mcrm_pkg::*;
(
    input wire logic neg,
    input wire logic sumLoad,
    output mcrm_meas_t meas
);
    // values hold still between reads so that the bench can predict them
    always_comb begin
        meas = '0;
        meas.checksumLoad = sumLoad;
        meas.checksumValue = 32'h2468ACE0;
        for (int p = 0; p < PHASE_N; p++) begin
            meas.reactive[p] = (neg ? 24'h800001 : 24'h012345) + 24'(p);
            meas.apparent[p] = ~meas.reactive[p];
            meas.delay[p] = 16'hA000 + 16'(p);
        end
    end
endmodule

// File: tb/mcrm_regs_properties.sv
// concurrent checks on the register bank ports
`timescale 1ns/1ps
module mcrm_regs_properties
    import mcrm_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire mcrm_req_t req,
    input wire mcrm_rsp_t rsp,
    input wire mcrm_meas_t meas,
    input wire logic pulseIn,
    input wire logic reducedPowerMode,
    input wire mcrm_cfg_t cfg,
    input wire logic [7:0] lowPowerActive,
    input wire logic energyLatch
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (rst);
    AST_ANSWER:
        assert property (req.rdEn |=> rsp.valid) else $error("read not answered");
    AST_QUIET:
        assert property (!req.rdEn |=> !rsp.valid) else $error("answer without read");
    AST_SIGN_EXT:
        assert property (req.rdEn && req.addr == OFS_REACT_A |=> rsp.byteLen == LEN_32
            && rsp.data == {{8{$past(meas.reactive[0][23])}}, $past(meas.reactive[0])})
        else $error("power word not sign extended");
    AST_NOM_PAD:
        assert property (req.rdEn && req.addr == OFS_NOM_VOLT |=> rsp.data[31:24] == 8'h00
            && rsp.byteLen == LEN_32) else $error("nominal voltage not padded");
    AST_TRIM_PAD:
        assert property (req.rdEn && req.addr == OFS_TRIM_A |=> rsp.data[31:10] == '0
            && rsp.byteLen == LEN_16) else $error("trim word not padded");
    AST_DELAY:
        assert property (req.rdEn && req.addr == OFS_DELAY_1 |=>
            rsp.data == {16'h0000, $past(meas.delay[1])}) else $error("delay word wrong");
    AST_LINE_CYC:
        assert property (req.wrEn && req.addr == OFS_LINE_CYC |=>
            cfg.lineCycles == $past(req.wrData[15:0])) else $error("line count not written");
    AST_LOW_PWR:
        assert property (lowPowerActive == (reducedPowerMode ? cfg.lowPower : 8'h00))
        else $error("low power config misapplied");
    AST_LATCH_CAUSE:
        assert property (energyLatch |-> $past(pulseIn)) else $error("latch without pulse");
    AST_RO_IGNORED:
        assert property (req.wrEn && req.addr == OFS_CHECKSUM |=> $stable(cfg))
        else $error("read-only write changed configuration");
    AST_LATCH_ONE:
        assert property (pulseIn && cfg.pulsesPerLatch == 8'h01 |=> energyLatch)
        else $error("latch missed");
endmodule
bind mcrm_regs mcrm_regs_properties chk (.clock, .rst, .req, .rsp, .meas, .pulseIn,
    .reducedPowerMode, .cfg, .lowPowerActive, .energyLatch);

// File: tb/tb_top.sv
// register access tests for the meter configuration register map
`timescale 1ns/1ps
`define CHK(a, b) begin checksDone++; if ((a) !== (b)) begin errors++; \
    $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module tb_top
    import mcrm_pkg::*;
;
    logic clock = 1'b0;
    logic rst = 1'b1;
    mcrm_req_t req = '0;
    logic pulseIn = 1'b0;
    logic reducedPowerMode = 1'b0;
    logic neg = 1'b1;
    logic sumLoad = 1'b0;
    mcrm_rsp_t rsp;
    mcrm_meas_t meas;
    mcrm_cfg_t cfg;
    logic [7:0] lowPowerActive;
    logic energyLatch;
    int errors = 0;
    int checksDone = 0;
    int cycles = 0;
    mcrm_regs dut (.clock, .rst, .req, .rsp, .meas, .pulseIn, .reducedPowerMode, .cfg,
        .lowPowerActive, .energyLatch);
    mcrm_dsp_model mdl (.neg, .sumLoad, .meas);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d errors %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clock);
        req.addr <= a;
        req.wrData <= d;
        req.wrEn <= 1'b1;
        @(posedge clock);
        req.wrEn <= 1'b0;
    endtask
    // answer fields stand after the taking edge, so look one step past it
    task automatic rd(input logic [15:0] a, input logic [31:0] e, input logic [2:0] n,
        input logic h);
        @(posedge clock);
        req.addr <= a;
        req.rdEn <= 1'b1;
        @(posedge clock);
        req.rdEn <= 1'b0;
        #1;
        `CHK(rsp.valid, 1'b1)
        `CHK(rsp.hit, h)
        `CHK(rsp.data, e)
        `CHK(rsp.byteLen, n)
    endtask
    task automatic pulse(input logic e);
        @(posedge clock);
        pulseIn <= 1'b1;
        @(posedge clock);
        pulseIn <= 1'b0;
        #1;
        `CHK(energyLatch, e)
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial forever #5 clock = ~clock;
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (4) @(posedge clock);
        rst <= 1'b0;
        rd(OFS_CHECKSUM, 32'h93D774E6, LEN_32, 1'b1);
        rd(OFS_NOM_VOLT, 32'h0, LEN_32, 1'b1);
        rd(OFS_LINE_CYC, 32'hFFFF, LEN_16, 1'b1);
        rd(OFS_ZX_TOUT, 32'hFFFF, LEN_16, 1'b1);
        rd(OFS_COMP_MODE, 32'h01FF, LEN_16, 1'b1);
        rd(OFS_MEAS_MODE, 32'h16, LEN_8, 1'b1);
        rd(OFS_LINE_ACCUM, 32'h78, LEN_8, 1'b1);
        rd(OFS_PULSE_CFG, 32'h0E88, LEN_16, 1'b1);
        rd(OFS_PULSE3_DEN, 32'h0, LEN_16, 1'b1);
        rd(OFS_PEAK_CYC, 32'h0, LEN_8, 1'b1);
        rd(OFS_SAG_CYC, 32'h0, LEN_8, 1'b1);
        rd(OFS_PULSE_LATCH, 32'h01, LEN_8, 1'b1);
        rd(OFS_REACT_A, 32'hFF800001, LEN_32, 1'b1);
        rd(OFS_APPAR_C, 32'h007FFFFC, LEN_32, 1'b1);
        rd(OFS_DELAY_1, 32'h0000A001, LEN_16, 1'b1);
        rd(16'hE521, 32'h0, LEN_8, 1'b0);
        rd(OFS_SS_HELPER, 32'h0, LEN_8, 1'b0);
        rd(16'hEC00, 32'h0, LEN_8, 1'b0);
        wr(OFS_CHECKSUM, 32'h0);
        rd(OFS_CHECKSUM, 32'h93D774E6, LEN_32, 1'b1);
        @(posedge clock);
        sumLoad <= 1'b1;
        @(posedge clock);
        sumLoad <= 1'b0;
        rd(OFS_CHECKSUM, 32'h2468ACE0, LEN_32, 1'b1);
        wr(OFS_NOM_VOLT, 32'hFF800000);
        rd(OFS_NOM_VOLT, 32'h00800000, LEN_32, 1'b1);
        wr(OFS_TRIM_A, 32'hFFFF);
        neg <= 1'b0;
        rd(OFS_TRIM_A, 32'h03FF, LEN_16, 1'b1);
        rd(OFS_REACT_B, 32'h00012346, LEN_32, 1'b1);
        wr(OFS_LINE_CYC, 32'h1234);
        rd(OFS_LINE_CYC, 32'h1234, LEN_16, 1'b1);
        wr(OFS_LOW_POWER, 32'hA5);
        #1;
        `CHK(lowPowerActive, 8'h00)
        @(posedge clock);
        reducedPowerMode <= 1'b1;
        @(posedge clock);
        #1;
        `CHK(lowPowerActive, 8'hA5)
        pulse(1'b1);
        wr(OFS_PULSE_LATCH, 32'h02);
        pulse(1'b0);
        pulse(1'b1);
        pulse(1'b0);
        give_verdict();
    end
endmodule
